// ---- hw/atc_pkg.sv ----
package atc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_GTC = 8'h23;
  localparam logic [7:0] OFS_CTLA = 8'h30;
  localparam logic [7:0] OFS_CLK = 8'h31;
  localparam logic [7:0] OFS_CNT = 8'h32;
  localparam logic [7:0] OFS_CMP = 8'h33;
  localparam logic [7:0] OFS_FLAG = 8'h34;
  localparam logic [7:0] OFS_MASK = 8'h35;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GTC_HOLD = 7;
  localparam int GTC_APSR = 1;
  localparam int GTC_SPSR = 0;
  localparam int CTLA_WM_HI = 3;
  localparam int CTLA_WM_LO = 6;
  localparam int CLK_ASEL = 3;
  localparam int FLAG_CMP = 1;
  localparam int FLAG_OVF = 0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CTLA_MASK = 8'h48;
  localparam logic [7:0] CLK_MASK = 8'h0F;
  localparam logic [7:0] GTC_MASK = 8'h83;
  localparam logic [7:0] FLAG_MASK = 8'h03;
  localparam int PRE_W = 10;

  // ----------------------------------------------------------------
  // Clock select codes and counter modes
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;

  typedef enum logic [1:0] {
    ATC_NORMAL = 2'b00,
    ATC_PHASE = 2'b01,
    ATC_CTC = 2'b10,
    ATC_FAST = 2'b11
  } atc_mode_t;

endpackage : atc_pkg

// ---- hw/atc_tick_if.sv ----
interface atc_tick_if;
  logic tick;
  logic [2:0] clock_select_field;
  logic async_clock_select;
  logic hold_rst;
  logic xtal_edge;
  modport src (output tick, input clock_select_field, input async_clock_select,
    input hold_rst, input xtal_edge);
  modport snk (input tick, output clock_select_field, output async_clock_select,
    output hold_rst, output xtal_edge);
endinterface : atc_tick_if

// ---- hw/atc_prescaler.sv ----
module atc_prescaler #(
  parameter int PRE_W = atc_pkg::PRE_W
) (
  input wire logic clk,
  input wire logic rst,
  atc_tick_if.src tk
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (PRE_W < atc_pkg::PRE_W) begin : g_bad_width
    $error("Prescaler too narrow for the largest divider.");
  end

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic src_edge;
  logic hit;

  function automatic logic tap_hit(input logic [2:0] cs, input logic [PRE_W-1:0] p);
    logic r;
    r = 1'b0;
    case (cs)
      atc_pkg::CS_DIV1: r = 1'b1;
      atc_pkg::CS_DIV8: r = &p[2:0];
      atc_pkg::CS_DIV64: r = &p[5:0];
      atc_pkg::CS_DIV256: r = &p[7:0];
      default: r = &p[9:0];
    endcase
    return r;
  endfunction : tap_hit

  // ----------------------------------------------------------------
  // Tick generation
  // ----------------------------------------------------------------
  assign src_edge = tk.async_clock_select ? tk.xtal_edge : 1'b1;
  assign hit = tap_hit(tk.clock_select_field, pre_r);
  assign pre_nxt = tk.hold_rst ? '0 : (src_edge ? pre_r + 1'b1 : pre_r);
  assign tk.tick = src_edge && !tk.hold_rst && hit
    && (tk.clock_select_field != atc_pkg::CS_STOP);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

endmodule : atc_prescaler

// ---- hw/atc_timer.sv ----
// The plain strobed port was decided locally.
module atc_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic crystal_in_pin,
  output logic crystal_out_pin,
  input wire logic compare_ack,
  input wire logic overflow_ack,
  output logic compare_irq,
  output logic overflow_irq,
  output logic shared_prescaler_reset
);

  // ----------------------------------------------------------------
  // Registers and wires
  // ----------------------------------------------------------------
  logic [7:0] ctla_r;
  logic [7:0] clk_ctl_r;
  logic sync_hold_mode_r;
  logic [1:0] psr_r;
  logic [1:0] psr_nxt;
  logic [7:0] counter_value_r;
  logic [7:0] counter_value_nxt;
  logic [7:0] cmp_buf_r;
  logic [7:0] compare_value_r;
  logic [7:0] compare_value_nxt;
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;
  logic [1:0] mask_r;
  logic dir_r;
  logic dir_nxt;
  logic block_r;
  logic xtal_s1_r;
  logic xtal_s2_r;
  logic xtal_s3_r;
  logic [7:0] rdata_r;
  logic cirq_r;
  logic oirq_r;
  logic spsr_out_r;

  logic gtc_wr;
  logic ctla_wr;
  logic clk_wr;
  logic cnt_wr;
  logic cmp_wr;
  logic flag_wr;
  logic mask_wr;
  logic [7:0] rd_mux;
  atc_pkg::atc_mode_t mode;
  logic pwm_mode;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic match;
  logic tick;
  logic count_en;
  logic clear_en;
  logic ovf_set;
  logic cmp_set;
  logic [1:0] flag_clr;
  logic [1:0] flag_set;
  logic cmp_load;

  atc_tick_if tk ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign gtc_wr = bus_wr && (bus_addr == atc_pkg::OFS_GTC);
  assign ctla_wr = bus_wr && (bus_addr == atc_pkg::OFS_CTLA);
  assign clk_wr = bus_wr && (bus_addr == atc_pkg::OFS_CLK);
  assign cnt_wr = bus_wr && (bus_addr == atc_pkg::OFS_CNT);
  assign cmp_wr = bus_wr && (bus_addr == atc_pkg::OFS_CMP);
  assign flag_wr = bus_wr && (bus_addr == atc_pkg::OFS_FLAG);
  assign mask_wr = bus_wr && (bus_addr == atc_pkg::OFS_MASK);

  assign rd_mux =
    (bus_addr == atc_pkg::OFS_GTC) ? {sync_hold_mode_r, 5'h00, psr_r} :
    (bus_addr == atc_pkg::OFS_CTLA) ? ctla_r :
    (bus_addr == atc_pkg::OFS_CLK) ? clk_ctl_r :
    (bus_addr == atc_pkg::OFS_CNT) ? counter_value_r :
    (bus_addr == atc_pkg::OFS_CMP) ? cmp_buf_r :
    (bus_addr == atc_pkg::OFS_FLAG) ? {6'h00, flag_r} :
    (bus_addr == atc_pkg::OFS_MASK) ? {6'h00, mask_r} :
    atc_pkg::RST_BYTE;

  // ----------------------------------------------------------------
  // Prescaler control and synchronisation hold
  // ----------------------------------------------------------------
  assign psr_nxt = !gtc_wr ? psr_r :
    (bus_wdata[atc_pkg::GTC_HOLD] ?
      {bus_wdata[atc_pkg::GTC_APSR], bus_wdata[atc_pkg::GTC_SPSR]} :
      2'b00);

  assign tk.clock_select_field = clk_ctl_r[2:0];
  assign tk.async_clock_select = clk_ctl_r[atc_pkg::CLK_ASEL];
  assign tk.hold_rst = psr_r[1] || (gtc_wr && bus_wdata[atc_pkg::GTC_APSR]);
  assign tk.xtal_edge = xtal_s2_r && !xtal_s3_r;
  assign tick = tk.tick;

  atc_prescaler #(
    .PRE_W(atc_pkg::PRE_W)
  ) u_pre (
    .clk(clk),
    .rst(rst),
    .tk(tk.src)
  );

  // ----------------------------------------------------------------
  // Counter unit
  // ----------------------------------------------------------------
  assign mode = atc_pkg::atc_mode_t'({ctla_r[atc_pkg::CTLA_WM_HI],
    ctla_r[atc_pkg::CTLA_WM_LO]});
  assign pwm_mode = ctla_r[atc_pkg::CTLA_WM_LO];
  assign top_val = (mode == atc_pkg::ATC_CTC) ? compare_value_r : atc_pkg::CNT_MAX;
  assign at_top = (counter_value_r == top_val);
  assign at_bottom = (counter_value_r == atc_pkg::CNT_BOTTOM);
  assign at_max = (counter_value_r == atc_pkg::CNT_MAX);
  assign match = (counter_value_r == compare_value_r);
  assign clear_en = tick && (mode == atc_pkg::ATC_CTC) && at_top;
  assign count_en = tick && !clear_en;

  always_comb begin
    dir_nxt = dir_r;
    ovf_set = 1'b0;
    cmp_load = 1'b0;
    unique case (mode)
      atc_pkg::ATC_PHASE: begin
        if (tick && !dir_r && at_top) begin
          dir_nxt = 1'b1;
          cmp_load = 1'b1;
        end else if (tick && dir_r && at_bottom) begin
          dir_nxt = 1'b0;
          ovf_set = 1'b1;
        end
      end
      atc_pkg::ATC_FAST: begin
        dir_nxt = 1'b0;
        ovf_set = tick && at_max;
        cmp_load = tick && at_max;
      end
      atc_pkg::ATC_NORMAL, atc_pkg::ATC_CTC: begin
        dir_nxt = 1'b0;
        ovf_set = tick && at_max;
      end
    endcase
  end

  always_comb begin
    counter_value_nxt = counter_value_r;
    if (cnt_wr) begin
      counter_value_nxt = bus_wdata;
    end else if (clear_en) begin
      counter_value_nxt = atc_pkg::CNT_BOTTOM;
    end else if (count_en) begin
      counter_value_nxt = dir_nxt ? counter_value_r - 8'h01 : counter_value_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Compare unit and flags
  // ----------------------------------------------------------------
  assign compare_value_nxt = (!pwm_mode && cmp_wr) ? bus_wdata :
    (pwm_mode && cmp_load) ? cmp_buf_r : compare_value_r;
  assign cmp_set = tick && match && !block_r;
  assign flag_set = {cmp_set, ovf_set};
  assign flag_clr = ({2{flag_wr}} & bus_wdata[1:0]) | {compare_ack, overflow_ack};
  assign flag_nxt = (flag_r & ~flag_clr) | flag_set;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctla_r <= atc_pkg::RST_BYTE;
      clk_ctl_r <= atc_pkg::RST_BYTE;
      sync_hold_mode_r <= 1'b0;
      psr_r <= 2'b00;
      mask_r <= 2'b00;
      cmp_buf_r <= atc_pkg::RST_BYTE;
    end else begin
      if (ctla_wr) begin
        ctla_r <= bus_wdata & atc_pkg::CTLA_MASK;
      end
      if (clk_wr) begin
        clk_ctl_r <= bus_wdata & atc_pkg::CLK_MASK;
      end
      if (gtc_wr) begin
        sync_hold_mode_r <= bus_wdata[atc_pkg::GTC_HOLD];
      end
      psr_r <= psr_nxt;
      if (mask_wr) begin
        mask_r <= bus_wdata[1:0];
      end
      if (cmp_wr) begin
        cmp_buf_r <= bus_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_value_r <= atc_pkg::CNT_BOTTOM;
      compare_value_r <= atc_pkg::RST_BYTE;
      dir_r <= 1'b0;
      flag_r <= 2'b00;
      block_r <= 1'b0;
    end else begin
      counter_value_r <= counter_value_nxt;
      compare_value_r <= compare_value_nxt;
      dir_r <= dir_nxt;
      flag_r <= flag_nxt;
      block_r <= cnt_wr || (block_r && !tick);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xtal_s1_r <= 1'b0;
      xtal_s2_r <= 1'b0;
      xtal_s3_r <= 1'b0;
      rdata_r <= atc_pkg::RST_BYTE;
      cirq_r <= 1'b0;
      oirq_r <= 1'b0;
      spsr_out_r <= 1'b0;
    end else begin
      xtal_s1_r <= crystal_in_pin;
      xtal_s2_r <= xtal_s1_r;
      xtal_s3_r <= xtal_s2_r;
      rdata_r <= bus_rd ? rd_mux : atc_pkg::RST_BYTE;
      cirq_r <= flag_r[atc_pkg::FLAG_CMP] && mask_r[atc_pkg::FLAG_CMP];
      oirq_r <= flag_r[atc_pkg::FLAG_OVF] && mask_r[atc_pkg::FLAG_OVF];
      spsr_out_r <= psr_r[0] || (gtc_wr && bus_wdata[atc_pkg::GTC_SPSR]);
    end
  end

  assign bus_rdata = rdata_r;
  assign crystal_out_pin = xtal_s3_r;
  assign compare_irq = cirq_r;
  assign overflow_irq = oirq_r;
  assign shared_prescaler_reset = spsr_out_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cmp_event;
    cmp_set ##1 flag_r[1];
  endsequence

  sequence s_hold_kept;
    sync_hold_mode_r && psr_r[1] && !gtc_wr;
  endsequence

  AST_HOLD_KEEPS: assert property (s_hold_kept |=> psr_r[1] && !tick)
    else $error("Held prescaler reset was lost.");
  AST_HOLD_CLEAR: assert property (gtc_wr && !bus_wdata[7] |=> psr_r == 2'b00)
    else $error("Prescaler resets not cleared with hold.");
  AST_SHARED_SELF: assert property (gtc_wr && bus_wdata[0] && !bus_wdata[7]
    |=> shared_prescaler_reset && !psr_r[0])
    else $error("Shared prescaler reset did not self-clear.");
  AST_STOPPED: assert property (clk_ctl_r[2:0] == 3'h0 |-> !tick
    && (cnt_wr || $stable(counter_value_nxt)))
    else $error("Tick while clock select is zero.");
  AST_WRITE_WINS: assert property (cnt_wr |=> counter_value_r == $past(bus_wdata))
    else $error("Counter write lost to count.");
  AST_CMP_IRQ: assert property (s_cmp_event ##0 mask_r[1] |=> compare_irq)
    else $error("Compare request not raised.");
  AST_BLOCK: assert property (cnt_wr ##1 (tick && match && !cnt_wr) |=> !flag_r[1]
    || $past(flag_r[1]))
    else $error("Compare after counter write not blocked.");
  AST_OVF_NORMAL: assert property (tick && mode == atc_pkg::ATC_NORMAL && at_max && !cnt_wr
    |=> flag_r[0] && counter_value_r == 8'h00)
    else $error("Normal mode wrap did not set overflow.");
  AST_CTC_CLEAR: assert property (tick && mode == atc_pkg::ATC_CTC && at_top && !cnt_wr
    |=> counter_value_r == 8'h00)
    else $error("Clear-on-compare did not clear counter.");
  AST_FLAG_CLR: assert property (flag_wr && bus_wdata[1] && !cmp_set |=> !flag_r[1])
    else $error("Compare flag not cleared by write of one.");

endmodule : atc_timer

// ---- tb/atc_timer_bench.sv ----
module atc_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } atc_row_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic crystal_in_pin = 1'b0;
  logic crystal_out_pin;
  logic compare_ack = 1'b0;
  logic overflow_ack = 1'b0;
  logic compare_irq;
  logic overflow_irq;
  logic shared_prescaler_reset;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] d;
  logic ok;

  atc_row_t rows [19] = '{
    '{1'b0, atc_pkg::OFS_GTC, 8'h00, 8'h00},
    '{1'b0, atc_pkg::OFS_CTLA, 8'h00, 8'h00},
    '{1'b0, atc_pkg::OFS_CLK, 8'h00, 8'h00},
    '{1'b0, atc_pkg::OFS_CNT, 8'h00, 8'h00},
    '{1'b0, atc_pkg::OFS_CMP, 8'h00, 8'h00},
    '{1'b0, atc_pkg::OFS_FLAG, 8'h00, 8'h00},
    '{1'b0, atc_pkg::OFS_MASK, 8'h00, 8'h00},
    '{1'b0, 8'h40, 8'h00, 8'h00},
    '{1'b1, atc_pkg::OFS_CTLA, 8'hFF, 8'h48},
    '{1'b1, atc_pkg::OFS_CTLA, 8'h00, 8'h00},
    '{1'b1, atc_pkg::OFS_MASK, 8'hFF, 8'h03},
    '{1'b1, atc_pkg::OFS_CMP, 8'h5A, 8'h5A},
    '{1'b1, atc_pkg::OFS_CNT, 8'hA5, 8'hA5},
    '{1'b1, atc_pkg::OFS_CLK, 8'h08, 8'h08},
    '{1'b1, atc_pkg::OFS_CLK, 8'h00, 8'h00},
    '{1'b1, 8'h40, 8'hFF, 8'h00},
    '{1'b1, atc_pkg::OFS_GTC, 8'h82, 8'h82},
    '{1'b1, atc_pkg::OFS_GTC, 8'h00, 8'h00},
    '{1'b1, atc_pkg::OFS_FLAG, 8'h03, 8'h00}
  };

  always #2.5 clk = ~clk;

  atc_timer dut_u (
    .clk(clk),
    .rst(rst),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .crystal_in_pin(crystal_in_pin),
    .crystal_out_pin(crystal_out_pin),
    .compare_ack(compare_ack),
    .overflow_ack(overflow_ack),
    .compare_irq(compare_irq),
    .overflow_irq(overflow_irq),
    .shared_prescaler_reset(shared_prescaler_reset)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task close_out;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    v = bus_rdata;
  endtask : rd

  task wait_sig(input int s, input int lim, output logic f);
    f = 1'b0;
    for (int k = 0; k < lim && !f; k++) begin
      @(posedge clk);
      #1;
      f = (s == 0) ? overflow_irq : (s == 1) ? compare_irq : shared_prescaler_reset;
    end
  endtask : wait_sig

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("outputs after reset", 8'h00, {5'h00, compare_irq, overflow_irq, shared_prescaler_reset});
    for (int i = 0; i < 19; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].wdata);
      end
      rd(rows[i].addr, d);
      chk("register", rows[i].exp, d);
    end
    $display("register table done");

    wr(atc_pkg::OFS_CNT, 8'h10);
    repeat (30) @(posedge clk);
    rd(atc_pkg::OFS_CNT, d);
    chk("stopped counter", 8'h10, d);
    $display("stopped counter done");

    wr(atc_pkg::OFS_CNT, 8'hFD);
    wr(atc_pkg::OFS_CLK, 8'h01);
    wait_sig(0, 40, ok);
    chk("overflow irq", 8'h01, {7'h00, ok});
    wr(atc_pkg::OFS_CLK, 8'h00);
    rd(atc_pkg::OFS_FLAG, d);
    chk("overflow flag", 8'h01, d);
    @(posedge clk);
    overflow_ack <= 1'b1;
    @(posedge clk);
    overflow_ack <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("overflow irq cleared", 8'h00, {7'h00, overflow_irq});
    rd(atc_pkg::OFS_FLAG, d);
    chk("flags after service", 8'h00, d);
    $display("overflow test done");

    wr(atc_pkg::OFS_CMP, 8'h05);
    wr(atc_pkg::OFS_CNT, 8'h00);
    wr(atc_pkg::OFS_CTLA, 8'h08);
    wr(atc_pkg::OFS_CLK, 8'h01);
    repeat (100) @(posedge clk);
    wr(atc_pkg::OFS_CLK, 8'h00);
    rd(atc_pkg::OFS_CNT, d);
    chk("clear on compare", 8'h01, {7'h00, d <= 8'h05});
    chk("compare irq", 8'h01, {7'h00, compare_irq});
    rd(atc_pkg::OFS_FLAG, d);
    chk("flags in clear mode", 8'h02, d);
    wr(atc_pkg::OFS_FLAG, 8'h02);
    rd(atc_pkg::OFS_FLAG, d);
    chk("compare flag cleared", 8'h00, d);
    #1;
    chk("compare irq cleared", 8'h00, {7'h00, compare_irq});
    $display("clear on compare test done");

    wr(atc_pkg::OFS_CTLA, 8'h00);
    wr(atc_pkg::OFS_CLK, 8'h01);
    wr(atc_pkg::OFS_CNT, 8'h80);
    rd(atc_pkg::OFS_CNT, d);
    chk("write while running", 8'h01, {7'h00, d >= 8'h80 && d <= 8'h83});
    wr(atc_pkg::OFS_CLK, 8'h00);
    $display("write priority test done");

    wr(atc_pkg::OFS_GTC, 8'h01);
    #1;
    chk("shared reset pulse", 8'h01, {7'h00, shared_prescaler_reset});
    rd(atc_pkg::OFS_GTC, d);
    chk("shared reset self clear", 8'h00, d);
    chk("shared reset low", 8'h00, {7'h00, shared_prescaler_reset});
    wr(atc_pkg::OFS_GTC, 8'h81);
    repeat (3) @(posedge clk);
    #1;
    chk("shared reset held", 8'h01, {7'h00, shared_prescaler_reset});
    rd(atc_pkg::OFS_GTC, d);
    chk("hold keeps bits", 8'h81, d);
    wr(atc_pkg::OFS_GTC, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk("shared reset released", 8'h00, {7'h00, shared_prescaler_reset});
    $display("prescaler reset test done");

    wr(atc_pkg::OFS_CNT, 8'h00);
    wr(atc_pkg::OFS_CLK, 8'h09);
    repeat (5) begin
      repeat (4) @(posedge clk);
      crystal_in_pin <= 1'b1;
      repeat (4) @(posedge clk);
      crystal_in_pin <= 1'b0;
    end
    repeat (10) @(posedge clk);
    wr(atc_pkg::OFS_CLK, 8'h00);
    rd(atc_pkg::OFS_CNT, d);
    chk("crystal ticks", 8'h05, d);
    @(posedge clk);
    crystal_in_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("crystal out level", 8'h01, {7'h00, crystal_out_pin});
    @(posedge clk);
    crystal_in_pin <= 1'b0;
    $display("crystal source test done");

    wr(atc_pkg::OFS_CTLA, 8'h40);
    wr(atc_pkg::OFS_CNT, 8'hFE);
    wr(atc_pkg::OFS_CLK, 8'h01);
    wait_sig(0, 600, ok);
    chk("phase overflow irq", 8'h01, {7'h00, ok});
    wr(atc_pkg::OFS_CLK, 8'h00);
    rd(atc_pkg::OFS_FLAG, d);
    chk("phase flags", 8'h03, d);
    @(posedge clk);
    compare_ack <= 1'b1;
    @(posedge clk);
    compare_ack <= 1'b0;
    rd(atc_pkg::OFS_FLAG, d);
    chk("compare serviced", 8'h01, d);
    wr(atc_pkg::OFS_FLAG, 8'h01);
    rd(atc_pkg::OFS_FLAG, d);
    chk("phase flags cleared", 8'h00, d);
    $display("phase mode test done");
    close_out();
  end

endmodule : atc_timer_bench
